// ==== rtl/audio_dsp_pkg.sv ====
// constants, types and states shared by the audio dsp memory and numeric block
// What this block does
// - 24-bit audio io, 28-bit core words
// - data and coefficients are 5.23 twos complement
// - coefficient one encodes as 00 80 00 00
// - 24-bit input sign-extended to 28 bits
// - output clipper saturates to 24 bits
// - full 1024-instruction budget runs every sample at rate setting 0
// - rate setting shortens budget for 2x, 4x, 8x
// - default program passes input; outputs start muted
// - parameter ram 1024x32 at 0..1023
// - program ram 1024x40 at 1024..2047
// - memories read zero, program holds default
// - program ram filled from boot rom contents
// - parameter words zero-padded to 32 bits
// - direct parameter writes steal core access
// - five safeload pairs copied when ram idle
// - safeload targets parameter ram only
// - 2k-word data ram hidden from host
// - delays step whole samples, 2048 deep
// - safeload entry: 10-bit address, 28-bit data
package audio_dsp_pkg;
  localparam int PARAM_WORDS = 1024;
  localparam int PROG_WORDS = 1024;
  localparam int DATA_WORDS = 2048;
  localparam int INSTR_BUDGET = 1024;
  localparam int SL_SLOTS = 5;
  localparam int CORE_W = 28;
  localparam int IO_W = 24;
  localparam int FRAC_BITS = 23;
  localparam logic [11:0] PROG_BASE = 12'h400;
  localparam logic [11:0] MAP_END = 12'h800;
  localparam logic [31:0] COEF_ONE = 32'h0080_0000;
  localparam logic [23:0] CLIP_POS = 24'h7FFFFF;
  localparam logic [23:0] CLIP_NEG = 24'h800000;
  localparam int OP_MSB = 39;
  localparam int OP_LSB = 37;
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_LOAD = 3'h1;
  localparam logic [2:0] OP_MUL = 3'h2;
  localparam logic [2:0] OP_STORE = 3'h3;
  localparam logic [2:0] OP_DWR = 3'h4;
  localparam logic [2:0] OP_DRD = 3'h5;
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [39:0] data;
  } ctrl_req_type;
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [9:0] addr;
    logic [27:0] data;
  } sl_req_type;
  typedef struct packed {
    logic [9:0] addr;
    logic [27:0] data;
  } sl_entry_type;
  typedef enum {st_boot, st_wait, st_commit, st_run} seq_state_type;
endpackage

// ==== rtl/audio_dsp_memory_numeric.sv ====
// audio dsp core memories, sequencer, numeric path and safeload logic
module audio_dsp_memory_numeric (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // control port
  input wire audio_dsp_pkg::ctrl_req_type ctrl_req,
  output logic ctrl_ready,
  output logic rd_valid,
  output logic [39:0] rd_data,
  // safeload port
  input wire audio_dsp_pkg::sl_req_type sl_req,
  // audio stream
  input wire logic sample_tick,
  input wire logic [23:0] audio_in,
  output logic [23:0] audio_out,
  output logic out_valid,
  // core control
  input wire logic [1:0] rate_sel,
  input wire logic unmute,
  input wire logic clear_regs_n,
  // status
  output logic boot_done,
  output logic core_busy
);
  // =====================================================
  // storage
  logic [31:0] param_mem [audio_dsp_pkg::PARAM_WORDS];
  logic [39:0] prog_mem [audio_dsp_pkg::PROG_WORDS];
  logic [27:0] data_mem [audio_dsp_pkg::DATA_WORDS];
  audio_dsp_pkg::sl_entry_type sl_q [audio_dsp_pkg::SL_SLOTS];
  logic [4:0] pend_q;
  audio_dsp_pkg::seq_state_type state_q;
  logic [10:0] boot_q;
  logic [9:0] pc_q;
  logic [2:0] cidx_q;
  logic [10:0] dptr_q;
  logic [23:0] in_q;
  logic [27:0] acc_q;

  // boot rom: passthrough program, load then store
  function automatic logic [39:0] boot_prog(input logic [9:0] idx);
    logic [39:0] w;
    w = 40'h00_0000_0000;
    if (idx == 10'h000)
      w[audio_dsp_pkg::OP_MSB:audio_dsp_pkg::OP_LSB] = audio_dsp_pkg::OP_LOAD;
    else if (idx == 10'h001)
      w[audio_dsp_pkg::OP_MSB:audio_dsp_pkg::OP_LSB] = audio_dsp_pkg::OP_STORE;
    return w;
  endfunction

  // 5.23 core word to 24-bit output with saturation
  function automatic logic [23:0] clip(input logic [27:0] x);
    logic [23:0] y;
    y = x[23:0];
    if (!x[27] && (x[26:23] != 4'h0))
      y = audio_dsp_pkg::CLIP_POS;
    else if (x[27] && (x[26:23] != 4'hF))
      y = audio_dsp_pkg::CLIP_NEG;
    return y;
  endfunction

  // =====================================================
  // decode
  logic run;
  logic [39:0] instr;
  logic [2:0] op;
  logic [10:0] dadr;
  logic host_we;
  logic par_hw;
  logic prg_hw;
  logic [27:0] par_op;
  logic [27:0] sext_in;
  logic signed [55:0] prod;
  logic [10:0] budget;
  logic last_instr;
  logic cmt_we;
  logic sl_take;
  audio_dsp_pkg::sl_entry_type cmt_e;

  assign boot_done = (state_q != audio_dsp_pkg::st_boot);
  assign ctrl_ready = boot_done;
  assign core_busy = (state_q == audio_dsp_pkg::st_run);
  assign run = core_busy;
  assign instr = prog_mem[pc_q];
  assign op = instr[audio_dsp_pkg::OP_MSB:audio_dsp_pkg::OP_LSB];
  assign dadr = dptr_q + instr[10:0];
  assign host_we = ctrl_req.valid && ctrl_req.write && ctrl_ready;
  // address decode, nothing at or above the map end
  assign par_hw = host_we && (ctrl_req.addr < audio_dsp_pkg::PROG_BASE);
  assign prg_hw = host_we && (ctrl_req.addr >= audio_dsp_pkg::PROG_BASE)
    && (ctrl_req.addr < audio_dsp_pkg::MAP_END);
  // a direct write takes the operand away from the core
  assign par_op = par_hw ? 28'h000_0000 : param_mem[pc_q][27:0];
  assign sext_in = {{4{in_q[23]}}, in_q};
  assign prod = $signed(acc_q) * $signed(par_op);
  // fewer instructions per sample for faster streams
  assign budget = 11'(audio_dsp_pkg::INSTR_BUDGET) >> rate_sel;
  assign last_instr = (11'(pc_q) == budget - 11'h001);
  assign cmt_e = sl_q[cidx_q];
  assign cmt_we = (state_q == audio_dsp_pkg::st_commit) && pend_q[cidx_q];
  assign sl_take = sl_req.valid && boot_done && (sl_req.slot < 3'(audio_dsp_pkg::SL_SLOTS));

  // =====================================================
  // parameter and program ram writes
  always_ff @(posedge mclk)
  begin
    if (state_q == audio_dsp_pkg::st_boot)
    begin
      if (!boot_q[10])
      begin
        param_mem[boot_q[9:0]] <= 32'h0000_0000;
        prog_mem[boot_q[9:0]] <= boot_prog(boot_q[9:0]);
      end
    end
    else
    begin
      if (par_hw)
        param_mem[ctrl_req.addr[9:0]] <= {4'h0, ctrl_req.data[27:0]};
      if (prg_hw)
        prog_mem[ctrl_req.addr[9:0]] <= ctrl_req.data;
      // safeload copies only into parameter ram
      if (cmt_we)
        param_mem[cmt_e.addr] <= {4'h0, cmt_e.data};
    end
  end

  // data ram: core-only, cleared at boot
  always_ff @(posedge mclk)
  begin
    if (state_q == audio_dsp_pkg::st_boot)
      data_mem[boot_q] <= 28'h000_0000;
    else if (run && (op == audio_dsp_pkg::OP_DWR))
      data_mem[dadr] <= acc_q;
  end

  // =====================================================
  // control port read answer, one cycle later
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= 40'h00_0000_0000;
    end
    else
    begin
      rd_valid <= ctrl_req.valid && !ctrl_req.write && ctrl_ready;
      if (ctrl_req.valid && !ctrl_req.write && ctrl_ready)
      begin
        if (ctrl_req.addr < audio_dsp_pkg::PROG_BASE)
          rd_data <= {8'h00, param_mem[ctrl_req.addr[9:0]]};
        else if (ctrl_req.addr < audio_dsp_pkg::MAP_END)
          rd_data <= prog_mem[ctrl_req.addr[9:0]];
        else
          rd_data <= 40'h00_0000_0000;
      end
    end
  end

  // =====================================================
  // safeload slots; a new load beats the commit clear
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q <= 5'h00;
      for (int i = 0; i < audio_dsp_pkg::SL_SLOTS; i++)
        sl_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < audio_dsp_pkg::SL_SLOTS; i++)
      begin
        if (sl_take && (sl_req.slot == 3'(i)))
        begin
          sl_q[i] <= '{addr: sl_req.addr, data: sl_req.data};
          pend_q[i] <= 1'b1;
        end
        else if (cmt_we && (cidx_q == 3'(i)))
          pend_q[i] <= 1'b0;
      end
    end
  end

  // =====================================================
  // sequencer: boot, wait for sample, commit, run
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= audio_dsp_pkg::st_boot;
      boot_q <= 11'h000;
      pc_q <= 10'h000;
      cidx_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        audio_dsp_pkg::st_boot:
        begin
          boot_q <= boot_q + 11'h001;
          if (boot_q == 11'(audio_dsp_pkg::DATA_WORDS - 1))
            state_q <= audio_dsp_pkg::st_wait;
        end
        audio_dsp_pkg::st_wait:
        begin
          pc_q <= 10'h000;
          cidx_q <= 3'h0;
          if (sample_tick)
            state_q <= (pend_q != 5'h00) ? audio_dsp_pkg::st_commit
              : audio_dsp_pkg::st_run;
        end
        audio_dsp_pkg::st_commit:
        begin
          // every slot visited before the core starts
          cidx_q <= cidx_q + 3'h1;
          if (cidx_q == 3'(audio_dsp_pkg::SL_SLOTS - 1))
            state_q <= audio_dsp_pkg::st_run;
        end
        audio_dsp_pkg::st_run:
        begin
          pc_q <= pc_q + 10'h001;
          if (last_instr)
            state_q <= audio_dsp_pkg::st_wait;
        end
      endcase
    end
  end

  // sample capture and delay pointer, once per frame
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_q <= 24'h000000;
      dptr_q <= 11'h000;
    end
    else if ((state_q == audio_dsp_pkg::st_wait) && sample_tick)
    begin
      in_q <= audio_in;
      dptr_q <= dptr_q + 11'h001;
    end
  end

  // =====================================================
  // accumulator; held clear while core registers are cleared
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      acc_q <= 28'h000_0000;
    else if (!clear_regs_n)
      acc_q <= 28'h000_0000;
    else if (run)
    begin
      unique case (op)
        audio_dsp_pkg::OP_LOAD: acc_q <= sext_in;
        audio_dsp_pkg::OP_MUL: acc_q <= prod[50:23];
        audio_dsp_pkg::OP_DRD: acc_q <= data_mem[dadr];
        default: acc_q <= acc_q;
      endcase
    end
  end

  // output through clipper, zero while muted
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      audio_out <= 24'h000000;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= run && (op == audio_dsp_pkg::OP_STORE);
      if (!unmute)
        audio_out <= 24'h000000;
      else if (run && (op == audio_dsp_pkg::OP_STORE))
        audio_out <= clip(acc_q);
    end
  end

  // =====================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_sign_extend: assert property (run && op == audio_dsp_pkg::OP_LOAD && clear_regs_n
    |=> acc_q[27:23] == {5{in_q[23]}} && acc_q[22:0] == in_q[22:0])
    else $error("input not sign extended");
  a_unity_gain: assert property (run && op == audio_dsp_pkg::OP_MUL && clear_regs_n
    && par_op == audio_dsp_pkg::COEF_ONE[27:0] |=> $stable(acc_q))
    else $error("unity coefficient changed value");
  a_clip_pos: assert property (run && op == audio_dsp_pkg::OP_STORE && unmute
    && !acc_q[27] && acc_q[26:23] != 4'h0 ##1 unmute |-> audio_out == audio_dsp_pkg::CLIP_POS)
    else $error("positive overflow not saturated");
  a_clip_neg: assert property (run && op == audio_dsp_pkg::OP_STORE && unmute
    && acc_q[27] && acc_q[26:23] != 4'hF ##1 unmute |-> audio_out == audio_dsp_pkg::CLIP_NEG)
    else $error("negative overflow not saturated");
  a_pc_budget: assert property (run |-> 11'(pc_q) < budget)
    else $error("pc beyond instruction budget");
  a_frame_end: assert property (run && last_instr |=> state_q == audio_dsp_pkg::st_wait)
    else $error("run did not end at budget");
  a_boot_block: assert property (!boot_done |=> !rd_valid && !out_valid)
    else $error("request answered during boot");
  a_commit_bound: assert property (state_q == audio_dsp_pkg::st_commit
    |-> ##[1:5] run)
    else $error("safeload commit too long");
  a_direct_lose: assert property (run && par_hw |-> par_op == 28'h000_0000)
    else $error("core read during direct write");
  a_unmapped_wr: assert property (host_we && ctrl_req.addr >= audio_dsp_pkg::MAP_END
    |-> !par_hw && !prg_hw)
    else $error("unmapped write reached memory");
  a_mute_out: assert property (!unmute |=> audio_out == 24'h000000)
    else $error("output not muted");
  a_delay_step: assert property (state_q == audio_dsp_pkg::st_wait && sample_tick
    |=> dptr_q == 11'($past(dptr_q) + 11'h001))
    else $error("delay pointer did not step");

  c_boot_done: cover property ($rose(boot_done));
  c_commit: cover property (cmt_we ##[1:5] run);
  c_clip: cover property (out_valid && audio_out == audio_dsp_pkg::CLIP_POS);
  c_steal: cover property (run && par_hw);
endmodule

// ==== tb/host_model.sv ====
// host controller model driving the control and safeload ports
module host_model (
  // clock
  input wire logic mclk,
  // requests towards the core
  output var audio_dsp_pkg::ctrl_req_type ctrl_req,
  output var audio_dsp_pkg::sl_req_type sl_req,
  // read answer
  input wire logic rd_valid,
  input wire logic [39:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    ctrl_req = '0;
    sl_req = '0;
  end
  // ==========================================
  // one word per request, held across the taking edge
  task automatic access(input logic wr, input logic [11:0] adr, input logic [39:0] dat,
    output logic vld, output logic [39:0] rdat);
    @(posedge mclk);
    ctrl_req.valid <= 1'b1;
    ctrl_req.write <= wr;
    ctrl_req.addr <= adr;
    ctrl_req.data <= dat;
    @(posedge mclk);
    ctrl_req.valid <= 1'b0;
    ctrl_req.data <= ~dat; // released bus keeps no stale value
    #1;
    vld = rd_valid;
    rdat = rd_data;
  endtask
  // one safeload pair, address and data together
  task automatic sl_load(input logic [2:0] slot, input logic [9:0] adr, input logic [27:0] dat);
    @(posedge mclk);
    sl_req <= '{1'b1, slot, adr, dat};
    @(posedge mclk);
    sl_req.valid <= 1'b0;
    sl_req.data <= ~dat;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the audio dsp memory and numeric block
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [11:0] waddr;
    logic [39:0] wdata;
    logic [11:0] raddr;
    logic [39:0] rexp;
  } row_type;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic sample_tick = 1'b0;
  logic [23:0] audio_in = '0;
  logic [1:0] rate_sel = '0;
  logic unmute = 1'b0;
  logic clear_regs_n = 1'b1;
  audio_dsp_pkg::ctrl_req_type ctrl_req;
  audio_dsp_pkg::sl_req_type sl_req;
  logic ctrl_ready, rd_valid, out_valid, boot_done, core_busy, v;
  logic [39:0] rd_data, d;
  logic [23:0] audio_out;
  int error_cnt = 0;
  int checked = 0;
  int i;
  row_type rows [5] = '{
    '{12'h005, 40'hFF_F080_0000, 12'h005, 40'h00_0080_0000},
    '{12'h3FF, 40'h00_0FFF_FFFF, 12'h3FF, 40'h00_0FFF_FFFF},
    '{12'h7FF, 40'h1F_FFFF_FFFF, 12'h7FF, 40'h1F_FFFF_FFFF},
    '{12'h800, 40'hFF_FFFF_FFFF, 12'h800, 40'h00_0000_0000},
    '{12'hC05, 40'h00_0123_4567, 12'h005, 40'h00_0080_0000}};
  always #2 mclk = ~mclk;
  audio_dsp_memory_numeric u_dut (.mclk(mclk), .reset_n(reset_n), .ctrl_req(ctrl_req),
    .ctrl_ready(ctrl_ready), .rd_valid(rd_valid), .rd_data(rd_data), .sl_req(sl_req),
    .sample_tick(sample_tick), .audio_in(audio_in), .audio_out(audio_out),
    .out_valid(out_valid), .rate_sel(rate_sel), .unmute(unmute),
    .clear_regs_n(clear_regs_n), .boot_done(boot_done), .core_busy(core_busy));
  host_model u_host (.mclk(mclk), .ctrl_req(ctrl_req), .sl_req(sl_req),
    .rd_valid(rd_valid), .rd_data(rd_data));
  // ==========================================
  // closing report
  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [39:0] x);
    u_host.access(1'b1, a, x, v, d);
  endtask
  task automatic rd(input logic [11:0] a, output logic [39:0] x);
    u_host.access(1'b0, a, 40'h00_0000_0000, v, x);
    `CHK(v, 1'b1)
  endtask
  // one sample frame: tick, count busy cycles, catch the output word
  task automatic frame(input logic [23:0] din, input logic [23:0] dexp, input int budget);
    int busy_n;
    int k;
    logic [23:0] got;
    busy_n = 0;
    got = ~dexp;
    @(posedge mclk);
    sample_tick <= 1'b1;
    audio_in <= din;
    @(posedge mclk);
    sample_tick <= 1'b0;
    audio_in <= ~din;
    #1;
    // the cycle right after the taking edge is the first busy one when no safeload is pending
    for (k = 0; k < 1100 && !(busy_n > 0 && core_busy === 1'b0); k++)
    begin
      if (core_busy === 1'b1) busy_n++;
      if (out_valid === 1'b1) got = audio_out;
      @(posedge mclk);
      #1;
    end
    if (k >= 1100)
    begin
      error_cnt++;
      give_verdict();
    end
    `CHK(busy_n, budget)
    `CHK(got, dexp)
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (7) @(posedge mclk);
    #1;
    `CHK({boot_done, ctrl_ready, core_busy, rd_valid, out_valid}, 5'h00)
    `CHK({audio_out, rd_data}, 64'h0)
    @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 2100 && boot_done !== 1'b1; i++) @(posedge mclk);
    if (i >= 2100)
    begin
      error_cnt++;
      give_verdict();
    end
    rd(12'h000, d);
    `CHK(d, 40'h00_0000_0000)
    rd(12'h400, d);
    `CHK(d[39:37], audio_dsp_pkg::OP_LOAD)
    rd(12'h401, d);
    `CHK(d[39:37], audio_dsp_pkg::OP_STORE)
    frame(24'h812345, 24'h000000, 1024);
    @(posedge mclk);
    unmute <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      rate_sel <= i[1:0];
      frame(24'h812345 ^ 24'(i), 24'h812345 ^ 24'(i), 1024 >> i);
    end
    @(posedge mclk);
    rate_sel <= 2'h0;
    clear_regs_n <= 1'b0;
    foreach (rows[j])
    begin
      wr(rows[j].waddr, rows[j].wdata);
      rd(rows[j].raddr, d);
      `CHK(d, rows[j].rexp)
    end
    // load, multiply by param word 1, store
    wr(12'h400, 40'h20_0000_0000);
    wr(12'h401, 40'h40_0000_0000);
    wr(12'h402, 40'h60_0000_0000);
    wr(12'h001, 40'h00_0200_0000);
    @(posedge mclk);
    clear_regs_n <= 1'b1;
    frame(24'h400000, 24'h7FFFFF, 1024);
    frame(24'hC00000, 24'h800000, 1024);
    frame(24'h100000, 24'h400000, 1024);
    u_host.sl_load(3'h4, 10'h001, 28'h0800000);
    u_host.sl_load(3'h5, 10'h001, 28'h1000000);
    frame(24'h300000, 24'h300000, 1024);
    rd(12'h001, d);
    `CHK(d, 40'h00_0080_0000)
    // direct write taken on the multiply edge: operand lost, output silent
    fork
      frame(24'h300000, 24'h000000, 1024);
      begin
        repeat (2) @(posedge mclk);
        wr(12'h003, 40'h00_0000_0000);
      end
    join
    // one-sample delay through the data ram: load, write, read back base-1, store
    wr(12'h401, 40'h80_0000_0000);
    wr(12'h402, 40'hA0_0000_07FF);
    wr(12'h403, 40'h60_0000_0000);
    frame(24'h111111, 24'h000000, 1024);
    frame(24'h222222, 24'h111111, 1024);
    // reset in the middle of a frame, then a fresh boot restores the defaults
    @(posedge mclk);
    sample_tick <= 1'b1;
    @(posedge mclk);
    sample_tick <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({boot_done, core_busy, out_valid, audio_out}, 27'h0)
    @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 2100 && boot_done !== 1'b1; i++) @(posedge mclk);
    if (i >= 2100)
    begin
      error_cnt++;
      give_verdict();
    end
    rd(12'h401, d);
    `CHK(d[39:37], audio_dsp_pkg::OP_STORE)
    rd(12'h001, d);
    `CHK(d, 40'h00_0000_0000)
    give_verdict();
  end
endmodule
